//--- core/ccc_pkg.sv
package ccc_pkg;

  // =====================================================================
  // External-function word layout.
  localparam int EF_WIDTH = 18;
  localparam int EF_OUT_GATE = 0;
  localparam int EF_PRINT = 1;
  localparam int EF_PUNCH = 2;
  localparam int EF_IN_GATE = 3;
  localparam int EF_KEYB = 4;
  localparam int EF_READ = 5;
  localparam int EF_START = 6;

  // =====================================================================
  // Data widths and character codes.
  localparam int DATA_WIDTH = 8;
  localparam int CHAR_WIDTH = 6;
  localparam logic [CHAR_WIDTH-1:0] CH_MASTER_SPACE = 6'h00;
  localparam logic [CHAR_WIDTH-1:0] CH_UPPER_CASE = 6'h01;
  localparam logic [CHAR_WIDTH-1:0] CH_LOWER_CASE = 6'h02;
  localparam logic [CHAR_WIDTH-1:0] CH_LINE_FEED = 6'h03;
  localparam logic [CHAR_WIDTH-1:0] CH_CARRIAGE_RET = 6'h04;
  localparam logic [CHAR_WIDTH-1:0] CH_SPACE = 6'h05;
  localparam logic [CHAR_WIDTH-1:0] CH_FIRST_LETTER = 6'h06;

  // =====================================================================
  // Reset values.
  localparam logic [DATA_WIDTH-1:0] DATA_RESET = 8'h00;

  // =====================================================================
  // Sequencer states.
  typedef enum logic [1:0] {ccc_in_idle, ccc_in_advance, ccc_in_wait_ack} ccc_in_state_t;
  typedef enum logic [1:0] {ccc_out_idle, ccc_out_wait_ack, ccc_out_busy} ccc_out_state_t;

endpackage

//--- core/ccc_console_channel_controller.sv
module ccc_console_channel_controller
  import ccc_pkg::*;
#(
  parameter int DW = DATA_WIDTH
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Channel: external function
  input wire logic ef_strobe,
  input wire logic [EF_WIDTH-1:0] ef_word,
  // Channel: input data
  output logic [DW-1:0] in_data,
  output logic in_req,
  input wire logic in_ack,
  // Channel: output data
  input wire logic [DW-1:0] out_data,
  output logic out_req,
  input wire logic out_ack,
  // Panel switches, one-cycle pulses
  input wire logic pnl_print_set,
  input wire logic pnl_print_clr,
  input wire logic pnl_punch_set,
  input wire logic pnl_punch_clr,
  input wire logic pnl_keyb_set,
  input wire logic pnl_keyb_clr,
  input wire logic pnl_read_set,
  input wire logic pnl_read_clr,
  input wire logic pnl_start_set,
  input wire logic pnl_start_clr,
  input wire logic pnl_copy_set,
  input wire logic pnl_copy_clr,
  // Reader mechanism
  input wire logic rdr_sprocket,
  input wire logic [DW-1:0] rdr_holes,
  output logic rdr_clutch,
  // Keyboard
  input wire logic key_strobe,
  input wire logic [CHAR_WIDTH-1:0] key_code,
  // Perforator mechanism
  input wire logic pch_timing,
  output logic pch_drive,
  output logic [DW-1:0] pch_data,
  // Printer mechanism
  output logic prt_start,
  output logic [CHAR_WIDTH-1:0] prt_char,
  input wire logic prt_done,
  // Unit status
  output logic print_en,
  output logic punch_en,
  output logic keyb_en,
  output logic read_en,
  output logic reading
);

  // Key codes ride in the low bits of the data word, so the word must hold them.
  if (DW < CHAR_WIDTH) begin : gen_width_check
    $error("Data width too small for character code.");
  end

  // Cleared value of the input and output registers at any data width.
  localparam logic [DW-1:0] DATA_CLEAR = DW'(DATA_RESET);

  // ======================================================================
  // Input synchronisers for mechanism signals.
  logic [1:0] spr_s_r;
  logic [1:0] pct_s_r;
  logic [1:0] pdn_s_r;
  logic [1:0] key_s_r;
  logic key_d_r;
  logic [CHAR_WIDTH-1:0] key_m_r;
  logic [CHAR_WIDTH-1:0] key_c_r;
  logic [DW-1:0] hol_m_r;
  logic [DW-1:0] hol_c_r;
  logic pct_d_r;
  logic pdn_d_r;
  logic spr_d_r;

  // Key code and data holes pass the same two stages as their strobes, so the
  // captured value lines up with the detected edge.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      spr_s_r <= 2'h0;
      spr_d_r <= 1'b0;
      pct_s_r <= 2'h0;
      pdn_s_r <= 2'h0;
      key_s_r <= 2'h0;
      key_d_r <= 1'b0;
      pct_d_r <= 1'b0;
      pdn_d_r <= 1'b0;
      key_m_r <= '0;
      key_c_r <= '0;
      hol_m_r <= '0;
      hol_c_r <= '0;
    end else begin
      spr_s_r <= {spr_s_r[0], rdr_sprocket};
      pct_s_r <= {pct_s_r[0], pch_timing};
      pdn_s_r <= {pdn_s_r[0], prt_done};
      key_s_r <= {key_s_r[0], key_strobe};
      key_d_r <= key_s_r[1];
      spr_d_r <= spr_s_r[1];
      pct_d_r <= pct_s_r[1];
      pdn_d_r <= pdn_s_r[1];
      key_m_r <= key_code;
      key_c_r <= key_m_r;
      hol_m_r <= rdr_holes;
      hol_c_r <= hol_m_r;
    end
  end

  logic sprocket;
  logic spr_rise;
  logic key_rise;
  logic pch_rise;
  logic prt_rise;
  assign sprocket = spr_s_r[1];
  assign spr_rise = spr_s_r[1] & ~spr_d_r;
  assign key_rise = key_s_r[1] & ~key_d_r;
  assign pch_rise = pct_s_r[1] & ~pct_d_r;
  assign prt_rise = pdn_s_r[1] & ~pdn_d_r;

  // ======================================================================
  // Unit enables from function words and panel.
  // A panel clear beats a panel set pressed in the same cycle.
  function automatic logic unit_next(input logic cur, input logic gate, input logic bitv,
                                     input logic pset, input logic pclr);
    logic v;
    v = cur;
    if (gate) begin
      v = bitv;
    end
    if (pset) begin
      v = 1'b1;
    end
    if (pclr) begin
      v = 1'b0;
    end
    return v;
  endfunction

  logic out_gate;
  logic in_gate;
  logic copy_en_r;
  assign out_gate = ef_strobe & ef_word[EF_OUT_GATE];
  assign in_gate = ef_strobe & ef_word[EF_IN_GATE];

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      print_en <= 1'b0;
      punch_en <= 1'b0;
      keyb_en <= 1'b0;
      read_en <= 1'b0;
      reading <= 1'b0;
      copy_en_r <= 1'b0;
    end else begin
      print_en <= unit_next(print_en, out_gate, ef_word[EF_PRINT], pnl_print_set, pnl_print_clr);
      punch_en <= unit_next(punch_en, out_gate, ef_word[EF_PUNCH], pnl_punch_set, pnl_punch_clr);
      keyb_en <= unit_next(keyb_en, in_gate, ef_word[EF_KEYB], pnl_keyb_set, pnl_keyb_clr);
      read_en <= unit_next(read_en, in_gate, ef_word[EF_READ], pnl_read_set, pnl_read_clr);
      reading <= unit_next(reading, in_gate, ef_word[EF_READ] & ef_word[EF_START],
                           pnl_start_set, pnl_start_clr | pnl_read_clr);
      copy_en_r <= unit_next(copy_en_r, 1'b0, 1'b0, pnl_copy_set, pnl_copy_clr);
    end
  end

  // ======================================================================
  // Input sequencer: reader frames and keyboard characters.
  ccc_in_state_t in_st_r;
  logic rd_active;
  assign rd_active = reading & read_en;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      in_st_r <= ccc_in_idle;
      in_req <= 1'b0;
      in_data <= DATA_CLEAR;
      rdr_clutch <= 1'b0;
    end else begin
      case (in_st_r)
        ccc_in_idle: begin
          if (rd_active) begin
            if (sprocket) begin
              in_data <= hol_c_r;
              in_req <= 1'b1;
              in_st_r <= ccc_in_wait_ack;
            end else begin
              rdr_clutch <= 1'b1;
              in_st_r <= ccc_in_advance;
            end
          end else if (keyb_en && key_rise) begin
            in_data <= DW'(key_c_r);
            in_req <= 1'b1;
            in_st_r <= ccc_in_wait_ack;
          end
        end
        ccc_in_advance: begin
          if (!rd_active) begin
            rdr_clutch <= 1'b0;
            in_st_r <= ccc_in_idle;
          end else if (spr_rise) begin
            // Only a fresh hole ends an advance: the level alone would read the
            // frame just acknowledged a second time while it is still over the sensor.
            rdr_clutch <= 1'b0;
            in_data <= hol_c_r;
            in_req <= 1'b1;
            in_st_r <= ccc_in_wait_ack;
          end
        end
        ccc_in_wait_ack: begin
          // The request holds even if the unit is disabled meanwhile.
          if (in_ack) begin
            in_req <= 1'b0;
            in_data <= DATA_CLEAR;
            if (rd_active) begin
              rdr_clutch <= 1'b1;
              in_st_r <= ccc_in_advance;
            end else begin
              in_st_r <= ccc_in_idle;
            end
          end
        end
        default: begin
          in_st_r <= ccc_in_idle;
        end
      endcase
    end
  end

  // ======================================================================
  // Output sequencer: perforator and printer share the output register.
  ccc_out_state_t out_st_r;
  logic [DW-1:0] out_reg_r;
  logic pch_pend_r;
  logic prt_pend_r;
  logic echo_r;
  logic echo_busy_r;

  // A keyboard echo is printed only while the output side is idle, so it never
  // overwrites a computer character; one echo may be pending at a time.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      echo_r <= 1'b0;
    end else if (keyb_en && key_rise && in_st_r == ccc_in_idle && !rd_active && print_en && copy_en_r) begin
      echo_r <= 1'b1;
    end else if (out_st_r == ccc_out_idle) begin
      echo_r <= 1'b0;
    end
  end

  assign pch_data = out_reg_r;
  assign prt_char = out_reg_r[CHAR_WIDTH-1:0];

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      out_st_r <= ccc_out_idle;
      out_req <= 1'b0;
      out_reg_r <= DATA_CLEAR;
      pch_drive <= 1'b0;
      prt_start <= 1'b0;
      pch_pend_r <= 1'b0;
      prt_pend_r <= 1'b0;
      echo_busy_r <= 1'b0;
    end else begin
      prt_start <= 1'b0;
      case (out_st_r)
        ccc_out_idle: begin
          if (echo_r && print_en) begin
            out_reg_r <= DW'(key_c_r);
            prt_start <= 1'b1;
            prt_pend_r <= 1'b1;
            pch_pend_r <= 1'b0;
            echo_busy_r <= 1'b1;
            out_st_r <= ccc_out_busy;
          end else if (print_en || punch_en) begin
            out_req <= 1'b1;
            out_st_r <= ccc_out_wait_ack;
          end
        end
        ccc_out_wait_ack: begin
          // A unit disabled while its request stood still has its character
          // latched, but no mechanism is started for it.
          if (out_ack) begin
            out_reg_r <= out_data;
            out_req <= 1'b0;
            pch_pend_r <= punch_en;
            prt_pend_r <= print_en;
            prt_start <= print_en;
            echo_busy_r <= 1'b0;
            out_st_r <= ccc_out_busy;
          end
        end
        ccc_out_busy: begin
          if (pch_pend_r && pch_rise) begin
            pch_drive <= 1'b1;
          end
          if (pch_drive) begin
            pch_drive <= 1'b0;
            pch_pend_r <= 1'b0;
          end
          if (prt_pend_r && prt_rise) begin
            prt_pend_r <= 1'b0;
          end
          if (!pch_pend_r && !prt_pend_r) begin
            out_reg_r <= DATA_CLEAR;
            if ((print_en || punch_en) && !echo_r) begin
              out_req <= 1'b1;
              out_st_r <= ccc_out_wait_ack;
            end else begin
              out_st_r <= ccc_out_idle;
            end
          end
        end
        default: begin
          out_st_r <= ccc_out_idle;
        end
      endcase
    end
  end

endmodule

//--- bench/ccc_props.sv
module ccc_props
  import ccc_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Channel
  input wire logic ef_strobe,
  input wire logic [EF_WIDTH-1:0] ef_word,
  input wire logic [DATA_WIDTH-1:0] in_data,
  input wire logic in_req,
  input wire logic in_ack,
  input wire logic [DATA_WIDTH-1:0] out_data,
  input wire logic out_req,
  input wire logic out_ack,
  // Panel
  input wire logic pnl_print_set,
  input wire logic pnl_print_clr,
  input wire logic pnl_punch_set,
  input wire logic pnl_punch_clr,
  input wire logic pnl_keyb_set,
  input wire logic pnl_keyb_clr,
  input wire logic pnl_read_set,
  input wire logic pnl_read_clr,
  input wire logic pnl_start_set,
  input wire logic pnl_start_clr,
  // Units
  input wire logic pch_drive,
  input wire logic [DATA_WIDTH-1:0] pch_data,
  input wire logic print_en,
  input wire logic punch_en,
  input wire logic keyb_en,
  input wire logic read_en,
  input wire logic reading
);
  timeunit 1ns;
  timeprecision 1ps;
  // ====
  // Panel pulses win over a word in the same cycle, so words count only alone.
  wire pa = pnl_print_set | pnl_print_clr | pnl_punch_set | pnl_punch_clr | pnl_keyb_set | pnl_keyb_clr;
  wire efo = ef_strobe && !pa && !(pnl_read_set | pnl_read_clr | pnl_start_set | pnl_start_clr);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  a_out_gate_load: assert property (efo && ef_word[0] |=>
    print_en == $past(ef_word[1]) && punch_en == $past(ef_word[2])) else $error("output enables wrong");
  a_out_gate_hold: assert property (efo && !ef_word[0] |=> $stable({print_en, punch_en}))
    else $error("output enables moved");
  a_in_gate_load: assert property (efo && ef_word[3] |=>
    keyb_en == $past(ef_word[4]) && read_en == $past(ef_word[5])) else $error("input enables wrong");
  a_start_read: assert property (efo && ef_word[3] |=> reading == $past(ef_word[5] & ef_word[6]))
    else $error("reading state wrong");
  a_in_gate_hold: assert property (efo && !ef_word[3] |=> $stable({keyb_en, read_en, reading}))
    else $error("input enables moved");
  a_punch_pulse: assert property (pch_drive |=> !pch_drive) else $error("punch drive too long");
  a_in_req_hold: assert property (in_req && !in_ack |=> in_req && $stable(in_data))
    else $error("input request dropped early");
  a_in_ack_clear: assert property (in_req && in_ack |=> !in_req && in_data == 8'h00)
    else $error("input not cleared on ack");
  a_out_ack_latch: assert property (out_req && out_ack |=> !out_req && pch_data == $past(out_data))
    else $error("output not latched");
  a_out_req_hold: assert property (out_req && !out_ack |=> out_req) else $error("output request lost");
  c_in: cover property (in_req && in_ack);
  c_out: cover property (out_req && out_ack);
  c_punch: cover property (pch_drive);
endmodule

//--- bench/ccc_host_model.sv
module ccc_host_model
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic in_req,
  input wire logic [7:0] in_data,
  output logic in_ack,
  output logic [7:0] in_seen,
  input wire logic out_req,
  input wire logic out_go,
  input wire logic [7:0] out_val,
  output logic [7:0] out_data,
  output logic out_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  // ====
  // Output data is scrambled outside a transfer so a late latch shows up.
  logic [1:0] ic;
  logic [1:0] oc;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      {ic, oc, in_ack, out_ack, in_seen, out_data} <= '0;
    end else begin
      in_ack <= 1'b0;
      out_ack <= 1'b0;
      if (in_req && !in_ack) begin
        ic <= ic + 2'h1;
        if (ic == 2'h2) begin
          in_ack <= 1'b1;
          in_seen <= in_data;
          ic <= 2'h0;
        end
      end
      if (out_req && !out_ack && out_go) begin
        oc <= oc + 2'h1;
        if (oc == 2'h0) out_data <= out_val;
        if (oc == 2'h2) begin
          out_ack <= 1'b1;
          oc <= 2'h0;
        end
      end else if (!out_ack) begin
        out_data <= ~out_data;
      end
    end
  end
endmodule

//--- bench/tb.sv
module tb
  import ccc_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 0, rst = 1, ef_strobe = 0, sp = 0, ks = 0, pt = 0, pd = 0, go = 0;
  logic [EF_WIDTH-1:0] ef_word = '0;
  logic [11:0] pnl = '0;
  logic [7:0] holes = '0, val = '0, m = '0;
  logic [5:0] kc = '0;
  wire [7:0] in_data, out_data, pch_data, seen;
  wire [5:0] prt_char;
  wire in_req, in_ack, out_req, out_ack, clutch, pch_drive, prt_start;
  wire print_en, punch_en, keyb_en, read_en, reading;
  wire [7:0] st = {3'h0, reading, read_en, keyb_en, punch_en, print_en};
  wire [6:0] mon = {out_req, !in_req, clutch, out_ack, pch_drive, prt_start, in_req};
  int fail_count = 0, checks_done = 0;
  always #20 mclk = ~mclk;
  ccc_console_channel_controller ccc_console_channel_controller_inst (.mclk, .rst, .ef_strobe, .ef_word,
    .in_data, .in_req, .in_ack, .out_data, .out_req, .out_ack, .pnl_print_set(pnl[0]), .pnl_print_clr(pnl[1]),
    .pnl_punch_set(pnl[2]), .pnl_punch_clr(pnl[3]), .pnl_keyb_set(pnl[4]), .pnl_keyb_clr(pnl[5]),
    .pnl_read_set(pnl[6]), .pnl_read_clr(pnl[7]), .pnl_start_set(pnl[8]), .pnl_start_clr(pnl[9]),
    .pnl_copy_set(pnl[10]), .pnl_copy_clr(pnl[11]), .rdr_sprocket(sp), .rdr_holes(holes), .rdr_clutch(clutch),
    .key_strobe(ks), .key_code(kc), .pch_timing(pt), .pch_drive, .pch_data, .prt_start, .prt_char, .prt_done(pd),
    .print_en, .punch_en, .keyb_en, .read_en, .reading);
  ccc_host_model ccc_host_model_inst (.mclk, .rst, .in_req, .in_data, .in_ack, .in_seen(seen), .out_req,
    .out_go(go), .out_val(val), .out_data, .out_ack);
  // ====
  // Bench tasks.
  task finish_test();
    $display("checks %0d fails %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp, input string s);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, s, got, exp);
    end
  endtask
  task wait_hi(input int k);
    int n;
    for (n = 0; n < 60 && mon[k] !== 1'b1; n++) tick(1);
    if (n == 60) begin
      fail_count++;
      $display("unexpected at %0t: wait %0d timed out", $time, k);
      finish_test();
    end
  endtask
  task ef(input logic [7:0] w);
    ef_word = {10'h000, w};
    ef_strobe = 1;
    tick(1);
    ef_strobe = 0;
    if (w[0]) m[1:0] = w[2:1];
    if (w[3]) m[4:2] = {w[5] & w[6], w[5], w[4]};
    chk(st, m, "ef status");
    tick(1);
  endtask
  // ====
  // Main sequence.
  initial begin
    tick(16);
    rst = 0;
    chk(st, 8'h00, "reset status");
    chk(in_data, 8'h00, "reset data");
    chk({6'h00, in_req, out_req}, 8'h00, "reset req");
    for (int i = 0; i < 10; i++) begin
      pnl[i] = 1;
      tick(1);
      pnl[i] = 0;
      m[i / 2] = !i[0];
      if (i == 7) m[4] = 0;
      chk(st, m, "panel status");
      tick(1);
    end
    ef(8'h07);
    ef(8'h06);
    ef(8'h05);
    ef(8'h01);
    ef(8'h78);
    ef(8'h50);
    ef(8'h38);
    ef(8'h08);
    ef(8'h68);
    tick(6);
    chk({7'h0, clutch}, 8'h01, "clutch on start");
    for (int j = 0; j < 2; j++) begin
      holes = j ? 8'h3c : 8'ha5;
      sp = 1;
      wait_hi(0);
      chk(in_data, holes, "frame data");
      chk({7'h0, clutch}, 8'h00, "clutch braked");
      wait_hi(4);
      sp = 0;
      chk(seen, holes, "host sample");
      chk(in_data, 8'h00, "frame cleared");
      tick(4);
      chk({7'h0, in_req}, 8'h00, "frame read twice");
    end
    ef(8'h18);
    for (int j = 0; j < 2; j++) begin
      kc = j ? CH_CARRIAGE_RET : CH_FIRST_LETTER;
      ks = 1;
      wait_hi(0);
      ks = 0;
      chk(in_data, {2'h0, kc}, "key code");
      wait_hi(5);
      chk(seen, {2'h0, kc}, "host key");
      tick(4);
    end
    ef(8'h08);
    ks = 1;
    tick(8);
    ks = 0;
    chk({7'h0, in_req}, 8'h00, "disabled key");
    ef(8'h05);
    val = 8'h5a;
    go = 1;
    wait_hi(3);
    go = 0;
    tick(1);
    chk(pch_data, val, "punch latch");
    pt = 1;
    wait_hi(2);
    pt = 0;
    wait_hi(6);
    chk(pch_data, 8'h00, "punch cleared");
    ef(8'h03);
    val = 8'h27;
    go = 1;
    wait_hi(1);
    go = 0;
    chk({2'h0, prt_char}, 8'h27, "print char");
    pd = 1;
    tick(2);
    wait_hi(6);
    pd = 0;
    chk(pch_data, 8'h00, "print cleared");
    ef(8'h18);
    pnl[10] = 1;
    tick(1);
    pnl[10] = 0;
    kc = CH_SPACE;
    ks = 1;
    wait_hi(0);
    ks = 0;
    wait_hi(5);
    val = 8'h11;
    go = 1;
    wait_hi(1);
    go = 0;
    chk({2'h0, prt_char}, val, "print before echo");
    pd = 1;
    tick(4);
    pd = 0;
    wait_hi(1);
    chk({2'h0, prt_char}, {2'h0, CH_SPACE}, "echo char");
    finish_test();
  end
endmodule
bind ccc_console_channel_controller ccc_props ccc_props_inst (.mclk, .rst, .ef_strobe, .ef_word, .in_data,
  .in_req, .in_ack, .out_data, .out_req, .out_ack, .pnl_print_set, .pnl_print_clr, .pnl_punch_set,
  .pnl_punch_clr, .pnl_keyb_set, .pnl_keyb_clr, .pnl_read_set, .pnl_read_clr, .pnl_start_set, .pnl_start_clr,
  .pch_drive, .pch_data, .print_en, .punch_en, .keyb_en, .read_en, .reading);
